// >>> design/sar_bank_rows.sv
// Purpose: Open-row bookkeeping, one entry per bank.
// Assumes: Commands arrive already decoded.
// Notes: Precharge and auto precharge both return a bank to idle.
module sar_bank_rows
	import sar_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic act,
	input wire logic [BANK_W-1:0] act_bank,
	input wire logic [ROW_W-1:0] act_row,
	input wire logic pre,
	input wire logic pre_all,
	input wire logic [BANK_W-1:0] pre_bank,
	input wire logic ap_close,
	input wire logic [BANK_W-1:0] ap_bank,
	output logic [NBANK-1:0] open_o,
	output logic [NBANK-1:0][ROW_W-1:0] rows_o
);
	typedef struct packed {
		logic [NBANK-1:0] open;
		logic [NBANK-1:0][ROW_W-1:0] rows;
	} sar_bank_state_s;

	sar_bank_state_s s_reg;
	sar_bank_state_s s_next;
	logic [NBANK-1:0] open_nx;
	logic [NBANK-1:0][ROW_W-1:0] row_nx;

	// ==========================================================
	// Per bank update
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit_act;
		logic hit_close;
		assign hit_act = act && act_bank == BANK_W'(b);
		assign hit_close = (pre && (pre_all || pre_bank == BANK_W'(b)))
			|| (ap_close && ap_bank == BANK_W'(b));
		assign open_nx[b] = hit_act ? 1'b1 : (hit_close ? 1'b0 : s_reg.open[b]);
		assign row_nx[b] = hit_act ? act_row : s_reg.rows[b];
	end

	always_comb begin
		s_next = s_reg;
		s_next.open = open_nx;
		s_next.rows = row_nx;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign open_o = s_reg.open;
	assign rows_o = s_reg.rows;
endmodule // sar_bank_rows

// >>> design/sar_mem.sv
// Purpose: Word array with byte write enables and a registered read.
// Assumes: Read and write share one address each cycle.
// Notes: Contents are not reset; read data lag the address by one edge.
module sar_mem #(
	parameter int AW = 22,
	parameter int DW = 32,
	parameter int BW = 4
) (
	input wire logic mclk,
	input wire logic [AW-1:0] addr,
	input wire logic [BW-1:0] we,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_reg
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// ==========================================================
	// Array
	for (genvar i = 0; i < BW; i++) begin : g_lane
		always_ff @(posedge mclk) begin
			if (we[i]) begin
				mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		rdata_reg <= mem[addr];
	end
endmodule // sar_mem

// >>> design/sar_pkg.sv
// Purpose: Shared constants and carrier types for the SDRAM read path.
// Assumes: One clock, synchronous active-high reset.
// Notes: Geometry defaults are four banks, 4K rows, 256 columns, x32.
package sar_pkg;

	// ==========================================================
	// Geometry
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int ADR_W = 12;
	localparam int DQ_W = 32;
	localparam int DQM_W = 4;
	localparam int MEM_AW_FULL = BANK_W + ROW_W + COL_W;

	// ==========================================================
	// Mode register layout
	localparam int MODE_W = 10;
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_OPM_LSB = 7;
	localparam int MR_WBM_BIT = 9;
	localparam logic [MODE_W-1:0] MODE_RESET = 10'h030;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_TWO = 3'h2;
	localparam int ADR_AP_BIT = 10;

	// ==========================================================
	// Command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_BT = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;

	// ==========================================================
	// Register map
	localparam int WB_AW = 8;
	localparam logic [WB_AW-1:0] REG_MODE = 8'h00;
	localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [WB_AW-1:0] REG_FLAGS = 8'h08;

	typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sar_burst_e;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] ba;
		logic [ADR_W-1:0] addr;
		logic [DQM_W-1:0] dqm;
	} sar_pins_s;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [WB_AW-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sar_wb_req_s;

endpackage

// >>> design/sar_sdram_read_path.sv
// Purpose: Device side of an SDRAM: mode register, row activation,
//	read burst pipeline, read truncation and output masking.
// Assumes: Command pins come from controller logic on mclk.
// Notes: Write path kept minimal; refresh and init are not modelled.
//
// Decided for this implementation: register access over Wishbone and the register addresses.

// Notes on behaviour
// - Write burst bit makes writes single-beat; with page length the code rewrites the start column each edge.
// - Read carries column, bank, auto precharge.
// - First word after latency, then each edge.
// - Data lines float when burst ends.
// - Page burst wraps to column zero.
// - Reads accepted every cycle, any open bank.
// - Write floats data if mask was active.
// - Timed precharge equals auto precharge.
// - Drive from edge n+m-1, valid n+m.
// - Mode fields: length, type, latency, modes.
module sar_sdram_read_path
	import sar_pkg::*;
#(
	parameter int MEM_AW = MEM_AW_FULL
) (
	input wire logic mclk,
	input wire logic rst,
	input wire sar_pins_s pins,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic [DQM_W-1:0] dq_oe,
	input wire sar_wb_req_s wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		logic [MODE_W-1:0] mode;
		sar_burst_e burst;
		logic [BANK_W-1:0] b_bank;
		logic [ROW_W-1:0] b_row;
		logic [COL_W-1:0] b_start;
		logic [COL_W-1:0] b_idx;
		logic b_ap;
		logic p1_v;
		logic p2_v;
		logic [DQ_W-1:0] p2_d;
		logic [DQM_W-1:0] dqm_d;
		logic [DQ_W-1:0] dq_out;
		logic [DQM_W-1:0] dq_oe;
		logic ack;
		logic [31:0] wb_dat;
		logic bad_wr;
		logic closed_hit;
	} sar_state_s;

	sar_state_s s_reg;
	sar_state_s s_next;

	logic [3:0] cmd;
	logic [DQ_W-1:0] mem_q;
	logic [MEM_AW-1:0] mem_addr;
	logic [DQM_W-1:0] mem_we;
	logic [NBANK-1:0] bank_open;
	logic [NBANK-1:0][ROW_W-1:0] bank_rows;
	logic act;
	logic pre;
	logic pre_all;
	logic ap_close;
	logic [COL_W-1:0] col;
	logic [COL_W-1:0] mask;
	logic page;
	logic pipe_busy;
	logic wb_go;
	logic ev_bad;
	logic ev_closed;

	// ==========================================================
	// Burst helpers
	function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
		case (code)
			BL_2: len_mask = COL_W'(1);
			BL_4: len_mask = COL_W'(3);
			BL_8: len_mask = COL_W'(7);
			BL_PAGE: len_mask = '1;
			default: len_mask = '0;
		endcase
	endfunction

	function automatic logic [COL_W-1:0] beat_col(
		input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] idx,
		input logic [COL_W-1:0] m,
		input logic inter
	);
		logic [COL_W-1:0] step;
		step = inter ? (start ^ idx) : (start + idx);
		beat_col = (start & ~m) | (step & m);
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		cmd = pins.cs_n ? CMD_NOP
			: {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
		mem_we = '0;
		mem_addr = '0;
		act = 1'b0;
		pre = 1'b0;
		pre_all = 1'b0;
		ap_close = 1'b0;
		col = '0;
		mask = '0;
		page = 1'b0;
		pipe_busy = s_reg.p1_v | s_reg.p2_v | (|s_reg.dq_oe);
		wb_go = wb_req.cyc && wb_req.stb && !s_reg.ack;
		ev_bad = 1'b0;
		ev_closed = 1'b0;

		// Output pipe: mask sampled two edges before the data edge
		s_next.dqm_d = pins.dqm;
		s_next.p1_v = 1'b0;
		s_next.p2_v = s_reg.p1_v;
		s_next.p2_d = mem_q;
		if (s_reg.mode[MR_CL_LSB +: 3] == CL_TWO) begin
			s_next.dq_out = mem_q;
			s_next.dq_oe = {DQM_W{s_reg.p1_v}} & ~s_reg.dqm_d;
		end else begin
			s_next.dq_out = s_reg.p2_d;
			s_next.dq_oe = {DQM_W{s_reg.p2_v}} & ~s_reg.dqm_d;
		end

		// Command decode
		case (cmd)
			CMD_ACT: begin
				act = 1'b1;
			end
			CMD_RD, CMD_WR: begin
				if (!bank_open[pins.ba]) begin
					s_next.closed_hit = 1'b1;
					ev_closed = 1'b1;
				end else if (cmd == CMD_WR && pipe_busy && !(&s_reg.dqm_d)) begin
					// Mask was low before the truncating write
					s_next.bad_wr = 1'b1;
					ev_bad = 1'b1;
				end else begin
					// New access truncates any running burst
					s_next.burst = (cmd == CMD_RD) ? BURST_READ : BURST_WRITE;
					s_next.b_bank = pins.ba;
					s_next.b_row = bank_rows[pins.ba];
					s_next.b_start = pins.addr[COL_W-1:0];
					s_next.b_idx = '0;
					s_next.b_ap = pins.addr[ADR_AP_BIT];
					if (cmd == CMD_WR) begin
						s_next.p2_v = 1'b0;
						s_next.dq_oe = '0;
					end
				end
			end
			CMD_BT: begin
				s_next.burst = BURST_IDLE;
			end
			CMD_PRE: begin
				pre = 1'b1;
				pre_all = pins.addr[ADR_AP_BIT];
				if (pre_all || pins.ba == s_reg.b_bank) begin
					s_next.burst = BURST_IDLE;
				end
			end
			CMD_LMR: begin
				s_next.mode = pins.addr[MODE_W-1:0];
			end
			default: begin
			end
		endcase

		// Beat issue: one column per edge
		page = s_reg.mode[MR_BL_LSB +: 3] == BL_PAGE;
		if (s_next.burst == BURST_WRITE && s_reg.mode[MR_WBM_BIT]) begin
			mask = '0;
		end else begin
			mask = len_mask(s_reg.mode[MR_BL_LSB +: 3]);
		end
		if (cmd == CMD_LMR) begin
			page = 1'b0;
		end
		// Page wraps through column zero by modular count
		col = beat_col(s_next.b_start, s_next.b_idx, mask,
			s_reg.mode[MR_BT_BIT] && !page);
		mem_addr = MEM_AW'({s_next.b_bank, s_next.b_row, col});
		if (s_next.burst != BURST_IDLE) begin
			if (s_next.burst == BURST_READ) begin
				s_next.p1_v = 1'b1;
			end else begin
				mem_we = ~pins.dqm;
			end
			// Last beat is the one whose index reaches the block mask
			if (!page && s_next.b_idx == mask) begin
				// End of a fixed burst: output floats after the pipe empties
				s_next.burst = BURST_IDLE;
				ap_close = s_next.b_ap;
			end
			s_next.b_idx = s_next.b_idx + COL_W'(1);
		end

		// Register bus
		s_next.ack = wb_go;
		s_next.wb_dat = '0;
		if (wb_go) begin
			case (wb_req.adr)
				REG_MODE: begin
					s_next.wb_dat = 32'(s_reg.mode);
					if (wb_req.we && cmd != CMD_LMR) begin
						if (wb_req.sel[0]) begin
							s_next.mode[7:0] = wb_req.dat[7:0];
						end
						if (wb_req.sel[1]) begin
							s_next.mode[MODE_W-1:8] = wb_req.dat[MODE_W-1:8];
						end
					end
				end
				REG_STATUS: begin
					s_next.wb_dat = {25'h0, (|s_reg.dq_oe),
						s_reg.burst == BURST_WRITE,
						s_reg.burst == BURST_READ, bank_open};
				end
				REG_FLAGS: begin
					s_next.wb_dat = {30'h0, s_reg.closed_hit, s_reg.bad_wr};
					// Write one clears; a new event in the same cycle wins
					if (wb_req.we && wb_req.sel[0]) begin
						if (wb_req.dat[0] && !ev_bad) begin
							s_next.bad_wr = 1'b0;
						end
						if (wb_req.dat[1] && !ev_closed) begin
							s_next.closed_hit = 1'b0;
						end
					end
				end
				default: begin
					s_next.wb_dat = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.mode <= MODE_RESET;
			s_reg.burst <= BURST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Storage and row state
	sar_mem #(
		.AW(MEM_AW),
		.DW(DQ_W),
		.BW(DQM_W)
	) u_mem (
		.mclk(mclk),
		.addr(mem_addr),
		.we(mem_we),
		.wdata(dq_in),
		.rdata_reg(mem_q)
	);

	sar_bank_rows u_rows (
		.mclk(mclk),
		.rst(rst),
		.act(act),
		.act_bank(pins.ba),
		.act_row(pins.addr[ROW_W-1:0]),
		.pre(pre),
		.pre_all(pre_all),
		.pre_bank(pins.ba),
		.ap_close(ap_close),
		.ap_bank(s_next.b_bank),
		.open_o(bank_open),
		.rows_o(bank_rows)
	);

	assign dq_out = s_reg.dq_out;
	assign dq_oe = s_reg.dq_oe;
	assign wb_dat_o = s_reg.wb_dat;
	assign wb_ack_o = s_reg.ack;
endmodule // sar_sdram_read_path

// >>> dv/sar_ctrl_model.sv
// Purpose: Controller side driving SDRAM command pins.
// Assumes: Tasks are called just after a rising edge.
// Notes: 20 ns spacings at 8 ns round up to 3 cycles.
module sar_ctrl_model
	import sar_pkg::*;
#(
	parameter int T_RCD = 3,
	parameter int T_RP = 3,
	parameter int T_MRD = 2
) (
	input wire logic mclk,
	output sar_pins_s pins,
	output logic [DQ_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pins = {CMD_NOP, 2'h0, 12'h000, 4'h0};
		dq_in = 32'h0;
	end
	// Released data line shows the inverse of its last value
	task automatic send(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
		pins <= {c, b, a, (c == CMD_WR) ? 4'h0 : m};
		dq_in <= (c == CMD_WR) ? d : ~dq_in;
		@(posedge mclk);
	endtask
	task automatic nop(input int n);
		repeat (n) send(CMD_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
	endtask
	task automatic act(input logic [1:0] b, input logic [11:0] r);
		send(CMD_ACT, b, r, 4'h0, 32'h0);
		nop(T_RCD - 1);
	endtask
	// Close every bank first: mode loads need all banks idle
	task automatic lmr(input logic [9:0] v);
		send(CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
		nop(T_RP - 1);
		send(CMD_LMR, 2'h0, {2'h0, v & 10'h27F}, 4'h0, 32'h0);
		nop(T_MRD - 1);
	endtask
endmodule // sar_ctrl_model

// >>> dv/sar_sdram_read_path_assertions.sv
// Purpose: Port checks for the SDRAM read path.
// Assumes: Only the top ports are visible.
// Notes: Latency is not tracked, so read timing allows 2 or 3.
module sar_sdram_read_path_assertions
	import sar_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire sar_pins_s pins,
	input wire logic [DQ_W-1:0] dq_in,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic [DQM_W-1:0] dq_oe,
	input wire sar_wb_req_s wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Decoded pins
	logic [3:0] cmd;
	logic req;
	assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
	assign req = wb_req.cyc && wb_req.stb;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Properties
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (req && !wb_ack_o && !$past(wb_ack_o)
		|=> wb_ack_o) else $error("bus request not answered");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_quiet_reset: assert property ($fell(rst) |-> dq_oe == 4'h0)
		else $error("data lines driven after reset");
	a_rd_drive: assert property (
		cmd == CMD_RD && pins.dqm == 4'h0 ##1 cmd == CMD_NOP
		&& pins.dqm == 4'h0 |-> ##[1:2] dq_oe == 4'hF)
		else $error("read data not driven in time");
	a_wr_float: assert property (
		cmd == CMD_WR && $past(pins.dqm) == 4'hF
		|=> dq_oe == 4'h0 ##1 dq_oe == 4'h0)
		else $error("write did not float data lines");
	a_mask_lat: assert property (
		pins.dqm != 4'h0 |-> ##2 (dq_oe & $past(pins.dqm, 2)) == 4'h0)
		else $error("masked byte still driven");
	a_mask_bytes: assert property (
		dq_oe != 4'h0 |-> (dq_oe | $past(pins.dqm, 2)) == 4'hF)
		else $error("unmasked byte not driven");
	c_read: cover property (cmd == CMD_RD ##2 dq_oe == 4'hF);
	c_wr_trunc: cover property (cmd == CMD_WR && $past(pins.dqm) == 4'hF);
	c_ack: cover property (wb_ack_o);
	c_bad_wr: cover property (cmd == CMD_WR && $past(pins.dqm) == 4'h0
		&& dq_oe != 4'h0);
endmodule // sar_sdram_read_path_assertions

// >>> dv/sdram_activate_read_path_test.sv
// Purpose: Self-checking bench for the SDRAM read path.
// Assumes: Array shortened with MEM_AW of 10.
// Notes: Expected words come from a shadow of what was written.
module sdram_activate_read_path_test
	import sar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	sar_pins_s pins;
	logic [DQ_W-1:0] dq_in, dq_out;
	logic [DQM_W-1:0] dq_oe;
	sar_wb_req_s wb_req = '0;
	logic [3:0] wb_sel = 4'hF;
	logic [31:0] wb_dat_o, q;
	logic wb_ack_o;
	int n_errors = 0;
	int samples_checked = 0;
	int bl;
	logic [7:0] col;
	logic [31:0] shadow [256];
	logic [31:0] exp_q [$];
	logic [9:0] modes [5] = '{10'h222, 10'h03A, 10'h023, 10'h030, 10'h222};
	logic [7:0] starts [5] = '{8'h01, 8'h01, 8'h05, 8'h06, 8'hFD};
	always #4 mclk = ~mclk;
	sar_ctrl_model ctl (.mclk(mclk), .pins(pins), .dq_in(dq_in));
	sar_sdram_read_path #(.MEM_AW(10)) uut (.mclk(mclk), .rst(rst),
		.pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: wb_sel, dat: d};
		do begin
			@(posedge mclk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 40);
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			complete_run();
		end else begin
			q = wb_dat_o;
			wb_req <= '0;
			@(posedge mclk);
		end
	endtask
	function automatic logic [7:0] col_at(input logic [7:0] s, input int n,
		input logic il, input int i);
		logic [7:0] m;
		m = 8'(n - 1);
		return il ? (s & ~m) | ((s ^ 8'(i)) & m) : (s & ~m) | ((s + 8'(i)) & m);
	endfunction
	task automatic rd_chk(input int lat);
		repeat (lat) @(posedge mclk);
		while (exp_q.size() > 0) begin
			#1;
			check(dq_out, exp_q.pop_front());
			check(32'(dq_oe), 32'h0000_000F);
			@(posedge mclk);
		end
		#1;
		check(32'(dq_oe), 32'h0);
	endtask
	task automatic rd(input logic [11:0] a, input int gap, input logic [3:0] c);
		ctl.send(CMD_RD, 2'h0, a, 4'h0, 32'h0);
		ctl.nop(gap);
		ctl.send(c, 2'h0, 12'h000, 4'h0, 32'h0);
		ctl.nop(8);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		wb(1'b0, REG_MODE, 32'h0);
		check(q, 32'h0000_0030);
		ctl.lmr(10'h222);
		ctl.act(2'h0, 12'h001);
		for (int c = 0; c < 12; c++) begin
			col = (c < 4) ? 8'(252 + c) : 8'(c - 4);
			shadow[col] = 32'h5A00_0000 | 32'(col);
			ctl.send(CMD_WR, 2'h0, {4'h0, col}, 4'h0, shadow[col]);
		end
		foreach (modes[j]) begin
			ctl.lmr(modes[j]);
			ctl.act(2'h0, 12'h001);
			bl = 1 << modes[j][2:0];
			for (int i = 0; i < bl; i++)
				exp_q.push_back(shadow[col_at(starts[j], bl, modes[j][3], i)]);
			fork
				rd({4'h0, starts[j]}, 0, CMD_NOP);
				rd_chk(modes[j][6:4] == CL_TWO ? 2 : 3);
			join
		end
		wb(1'b1, REG_MODE, 32'h0000_0223);
		wb(1'b0, REG_MODE, 32'h0);
		check(q, 32'h0000_0223);
		wb(1'b0, 8'h0C, 32'h0);
		check(q, 32'h0);
		ctl.lmr(10'h222);
		ctl.act(2'h0, 12'h001);
		exp_q = '{shadow[5], shadow[0], shadow[1], shadow[2], shadow[3]};
		fork
			rd(12'h005, 0, CMD_RD);
			rd_chk(2);
		join
		for (int k = 0; k < 2; k++) begin
			exp_q = '{shadow[4], shadow[5], shadow[6], shadow[7]};
			fork
				rd(k ? 12'h004 : 12'h404, 3, k ? CMD_PRE : CMD_NOP);
				rd_chk(2);
			join
			wb(1'b0, REG_STATUS, 32'h0);
			check(q & 32'h0000_000F, 32'h0);
			ctl.act(2'h0, 12'h001);
		end
		exp_q = '{shadow[0], shadow[1]};
		fork
			begin
				ctl.send(CMD_RD, 2'h0, 12'h000, 4'h0, 32'h0);
				ctl.nop(1);
				ctl.send(CMD_NOP, 2'h0, 12'h000, 4'hF, 32'h0);
				ctl.send(CMD_NOP, 2'h0, 12'h000, 4'hF, 32'h0);
				ctl.send(CMD_WR, 2'h0, 12'h003, 4'h0, 32'hB00D_0003);
				ctl.send(CMD_RD, 2'h0, 12'h000, 4'h0, 32'h0);
				// Mask low before this write while the read runs
				ctl.send(CMD_WR, 2'h0, 12'h002, 4'h0, 32'hB00D_0002);
				ctl.nop(8);
			end
			begin
				rd_chk(2);
				shadow[3] = 32'hB00D_0003;
				exp_q = '{shadow[0], shadow[1], shadow[2], shadow[3]};
				rd_chk(3);
			end
		join
		wb(1'b0, REG_FLAGS, 32'h0);
		check(q, 32'h0000_0001);
		exp_q = '{shadow[2], shadow[3], shadow[0], shadow[1]};
		fork
			rd(12'h002, 0, CMD_NOP);
			rd_chk(2);
		join
		wb(1'b1, REG_FLAGS, 32'h0000_0003);
		ctl.send(CMD_RD, 2'h1, 12'h000, 4'h0, 32'h0);
		ctl.send(CMD_NOP, 2'h0, 12'h000, 4'hF, 32'h0);
		ctl.nop(2);
		wb(1'b0, REG_FLAGS, 32'h0);
		check(q, 32'h0000_0002);
		ctl.lmr(10'h227);
		ctl.act(2'h0, 12'h001);
		exp_q = '{shadow[254], shadow[255], shadow[0], shadow[1]};
		fork
			rd(12'h0FE, 3, CMD_BT);
			rd_chk(2);
		join
		// Deselected load pattern must not touch the mode
		ctl.send(4'h8, 2'h0, 12'h000, 4'h0, 32'h0);
		wb_sel = 4'h2;
		wb(1'b1, REG_MODE, 32'h0);
		wb_sel = 4'hF;
		wb(1'b0, REG_MODE, 32'h0);
		check(q, 32'h0000_0027);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		complete_run();
	end
endmodule // sdram_activate_read_path_test

bind sar_sdram_read_path sar_sdram_read_path_assertions chk (.mclk(mclk),
	.rst(rst), .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
	.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
